// ==== logic/sfc_regs.sv ====
// forwarding configuration registers of the upstream port with arbiter and start logic
// assumes cfg and loader requests come from logic on clk_sys, addresses word aligned
`timescale 1ns/1ps
`include "sfc_map.svh"

module sfc_regs #(
	parameter logic [11:0] DEF_REPLAY = 12'h100,
	parameter logic [13:0] DEF_ACK    = 14'h0100,
	parameter int          N_PORTS    = 3,
	parameter int          LEN_W      = 12
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	// configuration access
	input  wire logic               cfg_wr,
	input  wire logic               cfg_rd,
	input  wire logic [7:0]         cfg_addr,
	input  wire logic [3:0]         cfg_be,
	input  wire logic [31:0]        cfg_wdata,
	output logic     [31:0]         cfg_rdata,
	output logic                    cfg_rvalid,
	// default loader, smbus or eeprom autoload
	input  wire logic               ld_wr,
	input  wire logic [7:0]         ld_addr,
	input  wire logic [31:0]        ld_wdata,
	// configuration outputs
	output logic     [31:0]         test_ctl_word,
	output logic     [11:0]         replay_limit,
	output logic     [13:0]         ack_latency,
	output logic                    vga_decode_en,
	output logic                    pm_cap_dis,
	output logic                    msi_cap_dis,
	output logic                    store_fwd_en,
	output logic                    credit_all_types,
	output logic                    order_egress_en,
	output logic                    order_cpl_tag_en,
	output logic     [5:0]          pm_ctrl_param,
	output logic                    rx_pol_inv_dis,
	output logic                    cpl_parity_dis,
	output logic     [4:0]          drv_lvl_3p5,
	output logic     [4:0]          drv_lvl_6p0,
	output logic     [4:0]          drv_lvl_half,
	// forwarding datapath
	input  wire logic               pkt_active,
	input  wire logic [LEN_W-1:0]   pkt_len,
	input  wire logic [LEN_W-1:0]   rx_count,
	input  wire logic               slow_to_fast,
	output logic                    fwd_go,
	// port arbitration
	input  wire logic [N_PORTS-1:0] arb_req,
	input  wire logic [N_PORTS-1:0] arb_credit_ok,
	output logic     [N_PORTS-1:0]  arb_grant,
	output logic                    arb_grant_vld
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
		return (old & ~m) | (wd & m);
	endfunction

	function automatic sfc_pkg::sfc_sel_t decode(input logic [7:0] a);
		logic [7:0] aw;
		aw = {a[7:2], 2'b00};
		if (aw == `SFC_OFS_TEST) begin
			return sfc_pkg::SFC_SEL_TEST;
		end else if (aw == `SFC_OFS_TIMER) begin
			return sfc_pkg::SFC_SEL_TIMER;
		end else if (aw == `SFC_OFS_MODE) begin
			return sfc_pkg::SFC_SEL_MODE;
		end
		return sfc_pkg::SFC_SEL_NONE;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// storage

	sfc_pkg::sfc_word_t test_reg;
	sfc_pkg::sfc_word_t test_next;
	sfc_pkg::sfc_word_t timer_reg;
	sfc_pkg::sfc_word_t timer_next;
	sfc_pkg::sfc_word_t mode_reg;
	sfc_pkg::sfc_word_t mode_next;
	sfc_pkg::sfc_word_t rdata_reg;
	sfc_pkg::sfc_word_t rdata_next;
	logic               rvalid_reg;
	logic [11:0]        replay_reg;
	logic [11:0]        replay_next;
	logic [13:0]        ack_reg;
	logic [13:0]        ack_next;

	////////////////////////////////////////////////////////////////////////////////
	// decode

	sfc_pkg::sfc_sel_t cfg_sel;
	sfc_pkg::sfc_sel_t ld_sel;
	logic [31:0]       cfg_bm;
	logic              cfg_wr_test;
	logic              cfg_wr_timer;
	logic              cfg_wr_mode;
	logic              ld_wr_test;
	logic              ld_wr_timer;
	logic              ld_wr_mode;

	assign cfg_sel      = decode(cfg_addr);
	assign ld_sel       = decode(ld_addr);
	assign cfg_bm       = be_mask(cfg_be);
	assign cfg_wr_test  = cfg_wr & (cfg_sel == sfc_pkg::SFC_SEL_TEST);
	assign cfg_wr_timer = cfg_wr & (cfg_sel == sfc_pkg::SFC_SEL_TIMER);
	assign cfg_wr_mode  = cfg_wr & (cfg_sel == sfc_pkg::SFC_SEL_MODE);
	assign ld_wr_test   = ld_wr & (ld_sel == sfc_pkg::SFC_SEL_TEST);
	assign ld_wr_timer  = ld_wr & (ld_sel == sfc_pkg::SFC_SEL_TIMER);
	assign ld_wr_mode   = ld_wr & (ld_sel == sfc_pkg::SFC_SEL_MODE);

	////////////////////////////////////////////////////////////////////////////////
	// write paths; loader wins over a configuration write in the same cycle

	logic [31:0] test_cfgw;
	logic [31:0] timer_cfgw;
	logic [31:0] mode_cfgw;

	// configuration writes touch only writable bits of enabled bytes
	assign test_cfgw  = merge(test_reg, cfg_wdata, cfg_bm & `SFC_CFGW_TEST);
	assign timer_cfgw = merge(timer_reg, cfg_wdata, cfg_bm & `SFC_CFGW_TIMER);
	assign mode_cfgw  = merge(mode_reg, cfg_wdata, cfg_bm & `SFC_CFGW_MODE);

	// loader replaces every implemented bit, read-only ones included
	assign test_next  = ld_wr_test  ? (ld_wdata & `SFC_IMPL_TEST)  :
	                    cfg_wr_test ? test_cfgw : test_reg;
	assign timer_next = ld_wr_timer ? (ld_wdata & `SFC_IMPL_TIMER) :
	                    cfg_wr_timer ? timer_cfgw : timer_reg;
	assign mode_next  = ld_wr_mode  ? (ld_wdata & `SFC_IMPL_MODE)  :
	                    cfg_wr_mode ? mode_cfgw : mode_reg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			test_reg  <= `SFC_RST_TEST;
			timer_reg <= `SFC_RST_TIMER;
			mode_reg  <= `SFC_RST_MODE;
		end else begin
			test_reg  <= test_next;
			timer_reg <= timer_next;
			mode_reg  <= mode_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path; unmapped offsets read zero, reserved bits are never stored

	assign rdata_next = (cfg_sel == sfc_pkg::SFC_SEL_TEST)  ? test_reg  :
	                    (cfg_sel == sfc_pkg::SFC_SEL_TIMER) ? timer_reg :
	                    (cfg_sel == sfc_pkg::SFC_SEL_MODE)  ? mode_reg  : 32'h00000000;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg  <= 32'h00000000;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= cfg_rd ? rdata_next : rdata_reg;
			rvalid_reg <= cfg_rd;
		end
	end

	assign cfg_rdata  = rdata_reg;
	assign cfg_rvalid = rvalid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// timer overrides

	assign replay_next = timer_reg[`SFC_REPLAY_EN] ?
	                     timer_reg[`SFC_REPLAY_MSB:`SFC_REPLAY_LSB] : DEF_REPLAY;
	assign ack_next    = timer_reg[`SFC_ACK_EN] ?
	                     timer_reg[`SFC_ACK_MSB:`SFC_ACK_LSB] : DEF_ACK;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			replay_reg <= DEF_REPLAY;
			ack_reg    <= DEF_ACK;
		end else begin
			replay_reg <= replay_next;
			ack_reg    <= ack_next;
		end
	end

	assign replay_limit = replay_reg;
	assign ack_latency  = ack_reg;

	////////////////////////////////////////////////////////////////////////////////
	// field outputs

	assign test_ctl_word    = test_reg;
	assign vga_decode_en    = timer_reg[`SFC_VGA_EN];
	assign pm_cap_dis       = timer_reg[`SFC_PMCAP_DIS];
	assign msi_cap_dis      = timer_reg[`SFC_MSICAP_DIS];
	assign store_fwd_en     = mode_reg[`SFC_STORE_FWD];
	assign credit_all_types = mode_reg[`SFC_CREDIT_ALL];
	assign order_egress_en  = mode_reg[`SFC_ORD_EGRESS];
	assign order_cpl_tag_en = mode_reg[`SFC_ORD_CPL_TAG];
	assign pm_ctrl_param    = mode_reg[`SFC_PMPARAM_MSB:`SFC_PMPARAM_LSB];
	assign rx_pol_inv_dis   = mode_reg[`SFC_RXPOL_DIS];
	assign cpl_parity_dis   = mode_reg[`SFC_CPLPAR_DIS];
	assign drv_lvl_3p5      = mode_reg[`SFC_DRV35_MSB:`SFC_DRV35_LSB];
	assign drv_lvl_6p0      = mode_reg[`SFC_DRV60_MSB:`SFC_DRV60_LSB];
	assign drv_lvl_half     = mode_reg[`SFC_DRVHALF_MSB:`SFC_DRVHALF_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// forwarding start point

	sfc_ct_start #(
		.LEN_W        (LEN_W)
	) u_ct_start (
		.clk_sys      (clk_sys),
		.rst_b        (rst_b),
		.pkt_active   (pkt_active),
		.pkt_len      (pkt_len),
		.rx_count     (rx_count),
		.slow_to_fast (slow_to_fast),
		.store_fwd    (mode_reg[`SFC_STORE_FWD]),
		.thr_code     (mode_reg[`SFC_THR_MSB:`SFC_THR_LSB]),
		.fwd_go       (fwd_go)
	);

	////////////////////////////////////////////////////////////////////////////////
	// port arbitration

	sfc_rr_arb #(
		.N            (N_PORTS)
	) u_rr_arb (
		.clk_sys      (clk_sys),
		.rst_b        (rst_b),
		.hold_mode    (mode_reg[`SFC_ARB_HOLD]),
		.req          (arb_req),
		.credit_ok    (arb_credit_ok),
		.grant        (arb_grant),
		.grant_vld    (arb_grant_vld)
	);

endmodule

// ==== logic/sfc_map.svh ====
// offsets, reset values, masks and field positions of the forwarding configuration registers
// assumes every user includes it by bare name; definitions only
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

`define SFC_OFS_TEST        8'h6c
`define SFC_OFS_TIMER       8'h70
`define SFC_OFS_MODE        8'h74

`define SFC_RST_TEST        32'h04000800
`define SFC_RST_TIMER       32'h80000000
`define SFC_RST_MODE        32'h0a730102

// bits that exist at all; loader may write these
`define SFC_IMPL_TEST       32'hffffffff
`define SFC_IMPL_TIMER      32'hffff7fff
`define SFC_IMPL_MODE       32'h7fffff7f
// bits that configuration writes may change
`define SFC_CFGW_TEST       32'hffffffff
`define SFC_CFGW_TIMER      32'h7fff1fff
`define SFC_CFGW_MODE       32'h00003f7f

`define SFC_REPLAY_MSB      11
`define SFC_REPLAY_LSB      0
`define SFC_REPLAY_EN       12
`define SFC_PMCAP_DIS       13
`define SFC_MSICAP_DIS      14
`define SFC_ACK_MSB         29
`define SFC_ACK_LSB         16
`define SFC_ACK_EN          30
`define SFC_VGA_EN          31

`define SFC_STORE_FWD       0
`define SFC_THR_MSB         2
`define SFC_THR_LSB         1
`define SFC_ARB_HOLD        3
`define SFC_CREDIT_ALL      4
`define SFC_ORD_EGRESS      5
`define SFC_ORD_CPL_TAG     6
`define SFC_PMPARAM_MSB     13
`define SFC_PMPARAM_LSB     8
`define SFC_RXPOL_DIS       14
`define SFC_CPLPAR_DIS      15
`define SFC_DRV35_MSB       20
`define SFC_DRV35_LSB       16
`define SFC_DRV60_MSB       25
`define SFC_DRV60_LSB       21
`define SFC_DRVHALF_MSB     30
`define SFC_DRVHALF_LSB     26

`endif

// ==== logic/sfc_pkg.sv ====
// types shared by the forwarding configuration block
// assumes sfc_map.svh supplies the numeric constants
package sfc_pkg;

	typedef logic [31:0] sfc_word_t;

	typedef enum logic [3:0] {
		SFC_SEL_NONE  = 4'h1,
		SFC_SEL_TEST  = 4'h2,
		SFC_SEL_TIMER = 4'h4,
		SFC_SEL_MODE  = 4'h8
	} sfc_sel_t;

endpackage

// ==== logic/sfc_ct_start.sv ====
// forwarding start point for store-forward and cut-through
// assumes rx_count counts datapath cycles of the packet received so far
`timescale 1ns/1ps
`include "sfc_map.svh"

module sfc_ct_start #(
	parameter int LEN_W = 12
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic             pkt_active,
	input  wire logic [LEN_W-1:0] pkt_len,
	input  wire logic [LEN_W-1:0] rx_count,
	input  wire logic             slow_to_fast,
	input  wire logic             store_fwd,
	input  wire logic [1:0]       thr_code,
	output logic                  fwd_go
);

	logic [LEN_W-1:0] mid_point;
	logic [LEN_W-1:0] lead;
	logic [LEN_W-1:0] ct_point;
	logic [LEN_W-1:0] start_point;
	logic             fwd_go_reg;
	logic             fwd_go_next;

	assign mid_point   = pkt_len >> 1;
	assign lead        = {{(LEN_W-2){1'b0}}, thr_code};
	assign ct_point    = slow_to_fast ? ((mid_point > lead) ? (mid_point - lead) : '0) : '0;
	assign start_point = store_fwd ? pkt_len : ct_point;
	assign fwd_go_next = pkt_active & (rx_count >= start_point);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fwd_go_reg <= 1'b0;
		end else begin
			fwd_go_reg <= fwd_go_next;
		end
	end

	assign fwd_go = fwd_go_reg;

endmodule

// ==== logic/sfc_rr_arb.sv ====
// round-robin port arbiter with optional hold on the granted port
// assumes req and credit_ok come from logic on clk_sys
`timescale 1ns/1ps

module sfc_rr_arb #(
	parameter int N = 3
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire logic         hold_mode,
	input  wire logic [N-1:0] req,
	input  wire logic [N-1:0] credit_ok,
	output logic     [N-1:0]  grant,
	output logic              grant_vld
);

	logic [N-1:0] grant_reg;
	logic [N-1:0] grant_next;
	logic         keep;
	logic [N-1:0] pick;

	// next candidate after the current grant, wrapping round
	function automatic logic [N-1:0] rr_pick(input logic [N-1:0] cand, input logic [N-1:0] cur);
		logic [N-1:0] p;
		int           base;
		int           k;
		p    = '0;
		base = N - 1;
		for (int i = 0; i < N; i++) begin
			if (cur[i]) begin
				base = i;
			end
		end
		for (int j = 1; j <= N; j++) begin
			k = (base + j) % N;
			if (cand[k] && (p == '0)) begin
				p[k] = 1'b1;
			end
		end
		return p;
	endfunction

	assign keep       = |(grant_reg & req) & (hold_mode | |(grant_reg & credit_ok));
	assign pick       = rr_pick(req & credit_ok, grant_reg);
	assign grant_next = keep ? grant_reg : pick;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			grant_reg <= '0;
		end else begin
			grant_reg <= grant_next;
		end
	end

	assign grant     = grant_reg;
	assign grant_vld = |grant_reg;

endmodule

// ==== dv/sfc_regs_sva.sv ====
// port checker for the forwarding configuration registers
// assumes a bind onto sfc_regs; one clock domain
`timescale 1ns/1ps

module sfc_regs_sva #(
	parameter logic [11:0] DEF_REPLAY = 12'h100,
	parameter logic [13:0] DEF_ACK    = 14'h0100,
	parameter int          N_PORTS    = 3,
	parameter int          LEN_W      = 12
) (
	input wire logic               clk_sys,
	input wire logic               rst_b,
	input wire logic               cfg_wr,
	input wire logic               cfg_rd,
	input wire logic [7:0]         cfg_addr,
	input wire logic [3:0]         cfg_be,
	input wire logic [31:0]        cfg_wdata,
	input wire logic [31:0]        cfg_rdata,
	input wire logic               cfg_rvalid,
	input wire logic               ld_wr,
	input wire logic [7:0]         ld_addr,
	input wire logic [11:0]        replay_limit,
	input wire logic [13:0]        ack_latency,
	input wire logic               vga_decode_en,
	input wire logic               store_fwd_en,
	input wire logic               pkt_active,
	input wire logic [LEN_W-1:0]   pkt_len,
	input wire logic [LEN_W-1:0]   rx_count,
	input wire logic               fwd_go,
	input wire logic [N_PORTS-1:0] arb_req,
	input wire logic [N_PORTS-1:0] arb_credit_ok,
	input wire logic [N_PORTS-1:0] arb_grant
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	logic [31:0] wd1_reg;
	logic [31:0] wd2_reg;
	// whole timer word written with no loader write to it
	wire tmr_wr = cfg_wr && cfg_addr[7:2] == 6'h1c && cfg_be == 4'hf && !(ld_wr && ld_addr[7:2] == 6'h1c);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wd1_reg <= 32'h0;
			wd2_reg <= 32'h0;
		end else begin
			wd1_reg <= cfg_wdata;
			wd2_reg <= wd1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	replay_sel_a: assert property (
		tmr_wr |-> ##2 replay_limit == (wd2_reg[12] ? wd2_reg[11:0] : DEF_REPLAY))
		else $error("replay limit wrong");
	ack_sel_a: assert property (
		tmr_wr |-> ##2 ack_latency == (wd2_reg[30] ? wd2_reg[29:16] : DEF_ACK))
		else $error("ack latency wrong");
	ro_keep_a: assert property (tmr_wr |=> $stable(vga_decode_en))
		else $error("vga decode bit written");
	sf_hold_a: assert property (pkt_active && store_fwd_en && rx_count < pkt_len |=> !fwd_go)
		else $error("forward before whole packet");
	mid_go_a: assert property (pkt_active && !store_fwd_en && rx_count >= (pkt_len >> 1) |=> fwd_go)
		else $error("no forward at midpoint");
	idle_go_a: assert property (!pkt_active |=> !fwd_go)
		else $error("forward with no packet");
	arb_new_a: assert property (
		$changed(arb_grant) && arb_grant != '0 |-> (arb_grant & $past(arb_req) & $past(arb_credit_ok)) != '0)
		else $error("grant to port without credit");
	arb_keep_a: assert property ((arb_grant & arb_req & arb_credit_ok) != '0 |=> arb_grant == $past(arb_grant))
		else $error("grant moved");
	rsv_zero_a: assert property (
		cfg_rd && cfg_addr[7:2] == 6'h1d |=> cfg_rvalid && !cfg_rdata[7] && !cfg_rdata[31])
		else $error("reserved mode bit set");
endmodule

// ==== dv/sfc_pkt_src.sv ====
// ingress packet source: raises a packet and counts its datapath cycles
// assumes go comes from the bench on clk_sys; the count stops at the length
`timescale 1ns/1ps

module sfc_pkt_src #(
	parameter int LEN_W = 12
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic             go,
	input  wire logic [LEN_W-1:0] pkt_len,
	output logic                  pkt_active,
	output logic     [LEN_W-1:0]  rx_count
);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pkt_active <= 1'b0;
			rx_count   <= '0;
		end else if (!go) begin
			pkt_active <= 1'b0;
			rx_count   <= '0;
		end else begin
			pkt_active <= 1'b1;
			if (pkt_active && rx_count < pkt_len)
				rx_count <= rx_count + 1'b1;
		end
	end
endmodule

// ==== dv/sfc_regs_bench.sv ====
// self-checking bench for the forwarding configuration registers
// assumes sfc_regs, sfc_pkt_src and sfc_regs_sva are compiled first
`timescale 1ns/1ps

module sfc_regs_bench;
	localparam logic [11:0] DEF_R = 12'h0a5;
	localparam logic [13:0] DEF_A = 14'h1234;
	logic        clk_sys = 1'b0, rst_b = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, ld_wr = 1'b0;
	logic        go = 1'b0, slow_to_fast = 1'b0, cfg_rvalid, vga_decode_en, store_fwd_en, fwd_go;
	logic        credit_all_types, order_egress_en, order_cpl_tag_en, pkt_active;
	logic [7:0]  cfg_addr = 8'h00, ld_addr = 8'h00;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, ld_wdata = 32'h0, cfg_rdata;
	logic [11:0] pkt_len = 12'h000, rx_count, replay_limit;
	logic [13:0] ack_latency;
	logic [2:0]  arb_req = 3'h0, arb_credit_ok = 3'h0, arb_grant;
	logic [31:0] test_ctl_word;
	logic [5:0]  pm_ctrl_param;
	logic [4:0]  drv_lvl_3p5, drv_lvl_6p0, drv_lvl_half;
	logic        pm_cap_dis, msi_cap_dis, rx_pol_inv_dis, cpl_parity_dis, arb_grant_vld;
	int          errors = 0, checks = 0;

	always #50 clk_sys = ~clk_sys;

	sfc_regs #(.DEF_REPLAY(DEF_R), .DEF_ACK(DEF_A)) sfc_regs_inst (
		.clk_sys, .rst_b, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
		.ld_wr, .ld_addr, .ld_wdata, .test_ctl_word, .replay_limit, .ack_latency, .vga_decode_en,
		.pm_cap_dis, .msi_cap_dis, .store_fwd_en, .credit_all_types, .order_egress_en,
		.order_cpl_tag_en, .pm_ctrl_param, .rx_pol_inv_dis, .cpl_parity_dis, .drv_lvl_3p5,
		.drv_lvl_6p0, .drv_lvl_half, .pkt_active, .pkt_len, .rx_count, .slow_to_fast, .fwd_go,
		.arb_req, .arb_credit_ok, .arb_grant, .arb_grant_vld
	);
	sfc_pkt_src sfc_pkt_src_inst (.clk_sys, .rst_b, .go, .pkt_len, .pkt_active, .rx_count);

	task automatic test_done();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		cfg_wr    <= 1'b1;
		cfg_addr  <= a;
		cfg_wdata <= d;
		cfg_be    <= be;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
	endtask

	// read data is valid exactly one cycle after the strobe
	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		cfg_rd   <= 1'b1;
		cfg_addr <= a;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		#1;
		check(name, cfg_rdata, exp);
		check("rvalid", {31'h0, cfg_rvalid}, 32'h1);
	endtask

	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	task automatic arb(input logic [2:0] r, input logic [2:0] c, input logic [2:0] exp);
		@(posedge clk_sys);
		arb_req       <= r;
		arb_credit_ok <= c;
		@(posedge clk_sys);
		#1;
		check("grant", {29'h0, arb_grant}, {29'h0, exp});
		check("grant valid", {31'h0, arb_grant_vld}, {31'h0, |exp});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		int n;
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd("test word", 8'h6c, 32'h04000800);
		rd("timer", 8'h70, 32'h80000000);
		rd("mode", 8'h74, 32'h0a730102);
		check("replay", {20'h0, replay_limit}, {20'h0, DEF_R});
		check("ack", {18'h0, ack_latency}, {18'h0, DEF_A});
		check("phy fields", {9'h0, pm_ctrl_param, rx_pol_inv_dis, cpl_parity_dis, drv_lvl_3p5, drv_lvl_6p0, drv_lvl_half},
			{9'h0, 6'h01, 1'b0, 1'b0, 5'h13, 5'h13, 5'h02});
		$display("test reset done");
		wr(8'h70, 32'hffffffff, 4'hf);
		rd("timer", 8'h70, 32'hffff1fff);
		settle();
		check("replay", {20'h0, replay_limit}, 32'hfff);
		check("ack", {18'h0, ack_latency}, 32'h3fff);
		wr(8'h70, 32'h2abc0def, 4'hf);
		wr(8'h70, 32'h00000000, 4'h2);
		rd("timer", 8'h70, 32'haabc00ef);
		settle();
		check("replay", {20'h0, replay_limit}, {20'h0, DEF_R});
		check("ack", {18'h0, ack_latency}, {18'h0, DEF_A});
		ld(8'h70, 32'h0000e000);
		rd("timer", 8'h70, 32'h00006000);
		check("ro bits", {29'h0, vga_decode_en, msi_cap_dis, pm_cap_dis}, 32'h3);
		$display("test timer done");
		wr(8'h74, 32'hffffffff, 4'hf);
		rd("mode", 8'h74, 32'h0a733f7f);
		check("flags", {28'h0, store_fwd_en, credit_all_types, order_egress_en, order_cpl_tag_en}, 32'hf);
		wr(8'h74, 32'h00000000, 4'hf);
		rd("mode", 8'h74, 32'h0a730000);
		check("flags", {28'h0, store_fwd_en, credit_all_types, order_egress_en, order_cpl_tag_en}, 32'h0);
		rd("unmapped", 8'h80, 32'h0);
		$display("test mode done");
		for (i = 0; i < 6; i++) begin
			wr(8'h74, {29'h0, i[1:0], i == 5}, 4'h1);
			slow_to_fast <= i < 4;
			pkt_len      <= 12'd10;
			go           <= 1'b1;
			for (n = 0; n < 30 && fwd_go !== 1'b1; n++) begin
				@(posedge clk_sys);
				#1;
			end
			if (n == 30) begin
				errors++;
				test_done();
			end
			check("start", {20'h0, rx_count}, i < 4 ? 6 - i : (i == 4 ? 1 : 10));
			@(posedge clk_sys);
			go <= 1'b0;
			settle();
		end
		$display("test forwarding done");
		wr(8'h74, 32'h00000000, 4'h1);
		arb(3'b011, 3'b011, 3'b001);
		arb(3'b011, 3'b010, 3'b010);
		arb(3'b000, 3'b000, 3'b000);
		wr(8'h74, 32'h00000008, 4'h1);
		arb(3'b011, 3'b011, 3'b001);
		arb(3'b011, 3'b010, 3'b001);
		$display("test arbiter done");
		wr(8'h6c, 32'h12345678, 4'hf);
		rd("test word", 8'h6c, 32'h12345678);
		check("test out", test_ctl_word, 32'h12345678);
		@(posedge clk_sys);
		rst_b   <= 1'b0;
		arb_req <= 3'h0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd("test word", 8'h6c, 32'h04000800);
		rd("mode", 8'h74, 32'h0a730102);
		check("grant", {29'h0, arb_grant}, 32'h0);
		check("grant valid", {31'h0, arb_grant_vld}, 32'h0);
		$display("test mid reset done");
		test_done();
	end

	task automatic ld(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		ld_wr    <= 1'b1;
		ld_addr  <= a;
		ld_wdata <= d;
		@(posedge clk_sys);
		ld_wr <= 1'b0;
	endtask
endmodule

bind sfc_regs sfc_regs_sva #(.DEF_REPLAY(DEF_REPLAY), .DEF_ACK(DEF_ACK), .N_PORTS(N_PORTS), .LEN_W(LEN_W))
	sfc_regs_sva_inst (.clk_sys, .rst_b, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
	.cfg_rvalid, .ld_wr, .ld_addr, .replay_limit, .ack_latency, .vga_decode_en, .store_fwd_en,
	.pkt_active, .pkt_len, .rx_count, .fwd_go, .arb_req, .arb_credit_ok, .arb_grant);
